// ### inc/jfp_pkg.sv
package jfp_pkg;
  localparam int JFP_IR_W = 4;
  localparam int JFP_CMD_W = 15;
  localparam int JFP_EN_W = 16;
  localparam int JFP_BYTE_W = 8;
  localparam int JFP_ADDR_W = 8;
  localparam int JFP_PAGE_LOAD_BITS = 2048;
  localparam int JFP_PAGE_READ_BITS = 2056;
  localparam int JFP_PAGE_BYTES = JFP_PAGE_LOAD_BITS / JFP_BYTE_W;
  localparam logic [3:0] JFP_PROGRAM_UNLOCK_INSTR = 4'h4;
  localparam logic [3:0] JFP_COMMAND_ENTRY_INSTR = 4'h5;
  localparam logic [3:0] JFP_PAGE_LOAD_INSTR = 4'h6;
  localparam logic [3:0] JFP_PAGE_READ_INSTR = 4'h7;
  localparam logic [3:0] JFP_IR_RESET = 4'hf;
  localparam logic [3:0] JFP_IR_CAPTURE = 4'h1;
  localparam logic [15:0] JFP_UNLOCK_SIG = 16'ha370;
  localparam logic [2:0] JFP_BIT_LAST = 3'h7;
  localparam logic [7:0] JFP_ADDR_RESET = 8'h00;

  typedef enum logic [3:0] {
    JFP_TLR, JFP_RTI, JFP_SEL_DR, JFP_CAP_DR, JFP_SH_DR, JFP_EX1_DR, JFP_PA_DR, JFP_EX2_DR,
    JFP_UPD_DR, JFP_SEL_IR, JFP_CAP_IR, JFP_SH_IR, JFP_EX1_IR, JFP_PA_IR, JFP_EX2_IR, JFP_UPD_IR
  } jfp_tap_state_t;

  function automatic jfp_tap_state_t jfp_next_state(input jfp_tap_state_t s, input logic tms);
    jfp_tap_state_t n;
    n = JFP_TLR;
    case (s)
      JFP_TLR: n = tms ? JFP_TLR : JFP_RTI;
      JFP_RTI: n = tms ? JFP_SEL_DR : JFP_RTI;
      JFP_SEL_DR: n = tms ? JFP_SEL_IR : JFP_CAP_DR;
      JFP_CAP_DR: n = tms ? JFP_EX1_DR : JFP_SH_DR;
      JFP_SH_DR: n = tms ? JFP_EX1_DR : JFP_SH_DR;
      JFP_EX1_DR: n = tms ? JFP_UPD_DR : JFP_PA_DR;
      JFP_PA_DR: n = tms ? JFP_EX2_DR : JFP_PA_DR;
      JFP_EX2_DR: n = tms ? JFP_UPD_DR : JFP_SH_DR;
      JFP_UPD_DR: n = tms ? JFP_SEL_DR : JFP_RTI;
      JFP_SEL_IR: n = tms ? JFP_TLR : JFP_CAP_IR;
      JFP_CAP_IR: n = tms ? JFP_EX1_IR : JFP_SH_IR;
      JFP_SH_IR: n = tms ? JFP_EX1_IR : JFP_SH_IR;
      JFP_EX1_IR: n = tms ? JFP_UPD_IR : JFP_PA_IR;
      JFP_PA_IR: n = tms ? JFP_EX2_IR : JFP_PA_IR;
      JFP_EX2_IR: n = tms ? JFP_UPD_IR : JFP_SH_IR;
      JFP_UPD_IR: n = tms ? JFP_SEL_DR : JFP_RTI;
      default: n = JFP_TLR;
    endcase
    return n;
  endfunction : jfp_next_state
endpackage : jfp_pkg

// ### inc/jfp_tap_if.sv
`timescale 1ns/100ps
`default_nettype none
interface jfp_tap_if;
  import jfp_pkg::*;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  logic ir_lsb;
  logic [3:0] ir;
  jfp_tap_state_t state;
  modport tap (output tck_rise, tck_fall, tms_s, tdi_s, ir_lsb, ir, state);
  modport core (input tck_rise, tck_fall, tms_s, tdi_s, ir_lsb, ir, state);
endinterface : jfp_tap_if
`default_nettype wire

// ### src/jfp_tap.sv
`timescale 1ns/100ps
`default_nettype none
module jfp_tap
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  jfp_tap_if.tap bus
);
  import jfp_pkg::*;

  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic [1:0] tdi_q;
  logic [3:0] ir_sh_q;
  logic [3:0] ir_q;
  jfp_tap_state_t state_q;

  // pins are asynchronous to clock; tms and tdi are read at the second stage, tck at the second and third
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tck_q <= 3'h0;
      tms_q <= 2'h3;
      tdi_q <= 2'h0;
    end
    else
    begin
      tck_q <= {tck_q[1:0], tck};
      tms_q <= {tms_q[0], tms};
      tdi_q <= {tdi_q[0], tdi};
    end
  end

  assign bus.tck_rise = tck_q[1] & ~tck_q[2];
  assign bus.tck_fall = ~tck_q[1] & tck_q[2];
  assign bus.tms_s = tms_q[1];
  assign bus.tdi_s = tdi_q[1];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= JFP_TLR;
    else if (bus.tck_rise)
      state_q <= jfp_next_state(state_q, tms_q[1]);
  end

  // instruction register, lsb first
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir_sh_q <= JFP_IR_RESET;
      ir_q <= JFP_IR_RESET;
    end
    else if (bus.tck_rise)
    begin
      case (state_q)
        JFP_TLR: ir_q <= JFP_IR_RESET;
        JFP_CAP_IR: ir_sh_q <= JFP_IR_CAPTURE;
        JFP_SH_IR: ir_sh_q <= {tdi_q[1], ir_sh_q[3:1]}; // R15 R16
        JFP_UPD_IR: ir_q <= ir_sh_q; // R16
        default: ir_q <= ir_q;
      endcase
    end
  end

  assign bus.ir = ir_q;
  assign bus.ir_lsb = ir_sh_q[0];
  assign bus.state = state_q;
endmodule : jfp_tap
`default_nettype wire

// ### src/jfp_prog.sv
// Operation
// R1: instruction 5 selects the 15-bit command shift register.
// R2: capture-dr loads the previous command result into the command register.
// R3: shift-dr moves the command register one bit per tck, tdi in, tdo out.
// R4: update-dr presents the shifted command to flash inputs without executing.
// R5: entering run-test/idle after update gives one execute pulse.
// R6: instruction 6 selects a 2048-bit virtual page-load chain.
// R7: page chains use an 8-bit shifter plus a byte mover.
// R8: page load never uses update-dr; bytes are written during shift-dr.
// R9: page-load data enters from tdi and is committed byte by byte.
// R10: instruction 7 selects a 2056-bit page-read chain, page plus eight bits.
// R11: page read never uses capture-dr; bytes are fetched during shift-dr. The code fetches byte 0 in capture-dr.
// R12: page-read data leaves on tdo each tck; tdi is ignored.
// R13: programmer uses page load only when first in the scan chain.
// R14: programmer uses page read only when first in the scan chain.
// R15: all shift registers shift lsb first, in and out.
// R16: the instruction register is four bits wide.
// R17: update-dr under unlock compares the 16-bit register with the signature.
// R18: commands and page transfers reach the flash only once unlocked.
`timescale 1ns/100ps
`default_nettype none
module jfp_prog
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [14:0] cmd_result,
  output logic [14:0] cmd_word,
  output logic cmd_exec,
  output logic prog_enabled,
  output logic pbuf_wr,
  output logic pbuf_rd,
  output logic [7:0] pbuf_addr,
  output logic [7:0] pbuf_wdata,
  input wire logic [7:0] pbuf_rdata
);
  import jfp_pkg::*;

  jfp_tap_if tap_bus ();

  jfp_tap u_tap
  (
    .clock(clock),
    .rst_n(rst_n),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .bus(tap_bus.tap)
  );

  logic rise;
  logic tdi_b;
  jfp_tap_state_t st;
  logic is_cmd;
  logic is_load;
  logic is_read;
  logic is_unlock;
  assign rise = tap_bus.tck_rise;
  assign tdi_b = tap_bus.tdi_s;
  assign st = tap_bus.state;
  assign is_cmd = tap_bus.ir == JFP_COMMAND_ENTRY_INSTR; // R1
  assign is_load = tap_bus.ir == JFP_PAGE_LOAD_INSTR; // R6
  assign is_read = tap_bus.ir == JFP_PAGE_READ_INSTR; // R10
  assign is_unlock = tap_bus.ir == JFP_PROGRAM_UNLOCK_INSTR;

  logic [14:0] cmd_sh_q;
  logic [14:0] cmd_word_q;
  logic exec_pend_q;
  logic cmd_exec_q;
  logic [15:0] en_sh_q;
  logic prog_en_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [7:0] addr_q;
  logic [7:0] prefetch_q;
  logic rd_pend_q;
  logic pbuf_wr_q;
  logic pbuf_rd_q;
  logic [7:0] pbuf_addr_q;
  logic [7:0] pbuf_wdata_q;
  logic bypass_q;
  logic tdo_q;
  logic tdo_oe_q;

  // command register: capture result, shift, update
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_sh_q <= '0;
      cmd_word_q <= '0;
    end
    else if (rise && is_cmd)
    begin
      case (st)
        JFP_CAP_DR: cmd_sh_q <= cmd_result; // R2
        JFP_SH_DR: cmd_sh_q <= {tdi_b, cmd_sh_q[14:1]}; // R3 R15
        JFP_UPD_DR: cmd_word_q <= cmd_sh_q; // R4
        default: cmd_sh_q <= cmd_sh_q;
      endcase
    end
  end

  // execute pulse only on the path update-dr straight into run-test/idle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exec_pend_q <= 1'b0;
      cmd_exec_q <= 1'b0;
    end
    else
    begin
      cmd_exec_q <= 1'b0;
      if (rise && is_cmd && st == JFP_UPD_DR)
        exec_pend_q <= !tap_bus.tms_s; // R5
      else if (exec_pend_q && st != JFP_UPD_DR)
      begin
        exec_pend_q <= 1'b0;
        cmd_exec_q <= (st == JFP_RTI) && prog_en_q; // R5 R18
      end
    end
  end

  // unlock register; cleared in test-logic-reset so a stale match cannot persist
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_sh_q <= '0;
      prog_en_q <= 1'b0;
    end
    else if (rise)
    begin
      if (st == JFP_TLR)
      begin
        en_sh_q <= '0;
        prog_en_q <= 1'b0;
      end
      else if (is_unlock && st == JFP_SH_DR)
        en_sh_q <= {tdi_b, en_sh_q[15:1]}; // R15
      else if (is_unlock && st == JFP_UPD_DR)
        prog_en_q <= en_sh_q == JFP_UNLOCK_SIG; // R17
    end
  end

  // shared 8-bit shifter for both virtual page chains
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q <= '0;
      bit_q <= '0;
      addr_q <= JFP_ADDR_RESET;
    end
    else if (rise && (is_load || is_read))
    begin
      if (st == JFP_CAP_DR)
      begin
        // counters rewind and the shifter clears here; the byte mover fetches byte 0 in capture
        sh_q <= '0; // R11
        bit_q <= '0;
        addr_q <= JFP_ADDR_RESET;
      end
      else if (st == JFP_SH_DR)
      begin
        bit_q <= bit_q + 3'h1; // R7
        if (is_read && bit_q == JFP_BIT_LAST)
        begin
          sh_q <= prefetch_q; // R11 R12
          addr_q <= addr_q + 8'h01;
        end
        else if (is_read)
          sh_q <= {1'b0, sh_q[7:1]}; // R12 R15
        else
        begin
          sh_q <= {tdi_b, sh_q[7:1]}; // R9 R15
          if (bit_q == JFP_BIT_LAST)
            addr_q <= addr_q + 8'h01;
        end
      end
    end
  end

  // byte mover: write completed bytes, prefetch next read byte
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pbuf_wr_q <= 1'b0;
      pbuf_rd_q <= 1'b0;
      rd_pend_q <= 1'b0;
      pbuf_addr_q <= '0;
      pbuf_wdata_q <= '0;
      prefetch_q <= '0;
    end
    else
    begin
      pbuf_wr_q <= 1'b0;
      pbuf_rd_q <= 1'b0;
      rd_pend_q <= pbuf_rd_q;
      if (rd_pend_q)
        prefetch_q <= pbuf_rdata;
      if (rise && st == JFP_SH_DR && bit_q == JFP_BIT_LAST && is_load)
      begin
        pbuf_wr_q <= prog_en_q; // R8 R9 R18
        pbuf_addr_q <= addr_q;
        pbuf_wdata_q <= {tdi_b, sh_q[7:1]};
      end
      else if (rise && is_read && (st == JFP_CAP_DR ||
               (st == JFP_SH_DR && bit_q == JFP_BIT_LAST)))
      begin
        // fetch runs a byte ahead, giving the eight leading pad bits
        pbuf_rd_q <= prog_en_q; // R11 R18
        pbuf_addr_q <= (st == JFP_CAP_DR) ? JFP_ADDR_RESET : addr_q + 8'h01;
        if (!prog_en_q)
          prefetch_q <= '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bypass_q <= 1'b0;
    else if (rise && st == JFP_SH_DR)
      bypass_q <= tdi_b;
  end

  // tdo changes on the falling tck edge, as the scan chain expects
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else if (tap_bus.tck_fall)
    begin
      tdo_oe_q <= st == JFP_SH_DR || st == JFP_SH_IR;
      if (st == JFP_SH_IR)
        tdo_q <= tap_bus.ir_lsb;
      else if (is_cmd)
        tdo_q <= cmd_sh_q[0]; // R3
      else if (is_unlock)
        tdo_q <= en_sh_q[0];
      else if (is_load || is_read)
        tdo_q <= sh_q[0]; // R12
      else
        tdo_q <= bypass_q;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;
  assign cmd_word = cmd_word_q;
  assign cmd_exec = cmd_exec_q;
  assign prog_enabled = prog_en_q;
  assign pbuf_wr = pbuf_wr_q;
  assign pbuf_rd = pbuf_rd_q;
  assign pbuf_addr = pbuf_addr_q;
  assign pbuf_wdata = pbuf_wdata_q;
endmodule : jfp_prog
`default_nettype wire

// ### bench/jfp_prog_chk.sv
`timescale 1ns/100ps
`default_nettype none
module jfp_prog_chk
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [14:0] cmd_result,
  input wire logic [14:0] cmd_word,
  input wire logic cmd_exec,
  input wire logic prog_enabled,
  input wire logic pbuf_wr,
  input wire logic pbuf_rd,
  input wire logic [7:0] pbuf_addr,
  input wire logic [7:0] pbuf_wdata,
  input wire logic [7:0] pbuf_rdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_exec_needs_unlock: assert property (cmd_exec |-> prog_enabled)
    else $error("execute while locked");
  a_wr_needs_unlock: assert property (pbuf_wr |-> prog_enabled)
    else $error("page write while locked");
  a_rd_needs_unlock: assert property (pbuf_rd |-> prog_enabled)
    else $error("page read while locked");
  // a new execute needs a whole scan, so pulses lie far apart
  a_exec_single: assert property (cmd_exec |=> !cmd_exec [*8])
    else $error("execute pulse repeated");
  a_exec_in_idle: assert property (cmd_exec |-> !tdo_oe && $stable(cmd_word))
    else $error("execute outside idle");
  a_wr_byte_spacing: assert property (pbuf_wr |=> !pbuf_wr [*8])
    else $error("page writes too close");
  a_rd_byte_spacing: assert property (pbuf_rd |=> !pbuf_rd [*8])
    else $error("page reads too close");
  a_wr_rd_apart: assert property (!(pbuf_wr && pbuf_rd))
    else $error("write and read together");
  c_exec: cover property (cmd_exec);
  c_wr: cover property (pbuf_wr);
  c_rd: cover property (pbuf_rd);
  c_unlock: cover property ($rose(prog_enabled));
endmodule : jfp_prog_chk
bind jfp_prog jfp_prog_chk u_jfp_prog_chk (.clock(clock), .rst_n(rst_n), .tck(tck),
  .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .cmd_result(cmd_result),
  .cmd_word(cmd_word), .cmd_exec(cmd_exec), .prog_enabled(prog_enabled),
  .pbuf_wr(pbuf_wr), .pbuf_rd(pbuf_rd), .pbuf_addr(pbuf_addr),
  .pbuf_wdata(pbuf_wdata), .pbuf_rdata(pbuf_rdata));
`default_nettype wire

// ### bench/jfp_prog_model.sv
`timescale 1ns/100ps
`default_nettype none
module jfp_prog_model
(
  input wire logic clock,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period of 8 clocks; tdo read just before the rise
  task automatic tick(input logic m, input logic d, output logic o);
    @(posedge clock);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clock);
    // a released pin reads as the inverse, so a dropped enable shows up
    o = (tdo_oe === 1'b1) ? tdo : ~tdo;
    tck <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : tick
  // sole device in the chain, so page load and read are allowed
  task automatic scan(input logic ir, input logic [2055:0] d, input int n,
    input logic end_tms, output logic [2055:0] q);
    logic o;
    q = '0;
    tick(1'b1, 1'b0, o);
    if (ir)
      tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, d[i], o);
      q[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(end_tms, 1'b0, o);
  endtask : scan
endmodule : jfp_prog_model
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module tb;
  import jfp_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, cmd_exec, prog_enabled, pbuf_wr, pbuf_rd, o;
  logic [14:0] cmd_result = 15'h0000;
  logic [14:0] cmd_word;
  logic [7:0] pbuf_addr, pbuf_wdata;
  logic [7:0] pbuf_rdata = 8'h00;
  logic [7:0] mem [256];
  logic [2055:0] q, d;
  int num_errors = 0;
  int checks = 0;
  int wr_cnt = 0;
  int exec_cnt = 0;
  always #10 clock = ~clock;
  // page buffer; data not read back shows the inverse of the last value
  always @(posedge clock)
  begin
    if (pbuf_wr === 1'b1)
      mem[pbuf_addr] <= pbuf_wdata;
    pbuf_rdata <= (pbuf_rd === 1'b1) ? mem[pbuf_addr] : ~pbuf_rdata;
    wr_cnt <= wr_cnt + int'(pbuf_wr === 1'b1);
    exec_cnt <= exec_cnt + int'(cmd_exec === 1'b1);
  end
  jfp_prog u_jfp_prog (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .cmd_result(cmd_result), .cmd_word(cmd_word),
    .cmd_exec(cmd_exec), .prog_enabled(prog_enabled), .pbuf_wr(pbuf_wr),
    .pbuf_rd(pbuf_rd), .pbuf_addr(pbuf_addr), .pbuf_wdata(pbuf_wdata),
    .pbuf_rdata(pbuf_rdata));
  jfp_prog_model u_jfp_prog_model (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe));
  task automatic cmd(input logic [14:0] v, input logic [14:0] res, input int exp);
    cmd_result <= res;
    u_jfp_prog_model.scan(1'b1, 2056'(JFP_COMMAND_ENTRY_INSTR), 4, 1'b0, q);
    `CHK(q[3:0], JFP_IR_CAPTURE)
    u_jfp_prog_model.scan(1'b0, 2056'(v), 15, 1'b0, q);
    // the update lands on the scan's last edge; look once it has settled
    @(negedge clock);
    `CHK(q[14:0], res)
    `CHK(cmd_word, v)
    `CHK(tdo_oe, 1'b0)
    repeat (8) @(posedge clock);
    `CHK(exec_cnt, exp)
  endtask : cmd
  task automatic unlock(input logic [15:0] sig, input logic exp);
    u_jfp_prog_model.scan(1'b1, 2056'(JFP_PROGRAM_UNLOCK_INSTR), 4, 1'b0, q);
    u_jfp_prog_model.scan(1'b0, 2056'(sig), 16, 1'b0, q);
    @(negedge clock);
    `CHK(prog_enabled, exp)
  endtask : unlock
  // unused opcodes leave one bypass bit between tdi and tdo
  task automatic bypass;
    u_jfp_prog_model.scan(1'b1, 2056'(JFP_IR_RESET), 4, 1'b0, q);
    u_jfp_prog_model.scan(1'b0, 2056'(8'hb5), 8, 1'b0, q);
    `CHK(q[7:1], 7'h35)
  endtask : bypass
  task automatic page_load;
    for (int k = 0; k < 256; k++)
      d[8 * k +: 8] = k[7:0] ^ 8'h5a;
    u_jfp_prog_model.scan(1'b1, 2056'(JFP_PAGE_LOAD_INSTR), 4, 1'b0, q);
    u_jfp_prog_model.scan(1'b0, d, 2048, 1'b0, q);
    repeat (8) @(posedge clock);
    `CHK(wr_cnt, 256)
    for (int k = 0; k < 256; k++)
      `CHK(mem[k], k[7:0] ^ 8'h5a)
  endtask : page_load
  task automatic page_read;
    u_jfp_prog_model.scan(1'b1, 2056'(JFP_PAGE_READ_INSTR), 4, 1'b0, q);
    u_jfp_prog_model.scan(1'b0, ~d, 2056, 1'b0, q);
    `CHK(q[7:0], 8'h00)
    for (int k = 0; k < 256; k++)
      `CHK(q[8 + 8 * k +: 8], k[7:0] ^ 8'h5a)
  endtask : page_read
  // leaving update towards select-dr must not execute
  task automatic no_exec;
    u_jfp_prog_model.scan(1'b1, 2056'(JFP_COMMAND_ENTRY_INSTR), 4, 1'b0, q);
    u_jfp_prog_model.scan(1'b0, 2056'(15'h0abc), 15, 1'b1, q);
    u_jfp_prog_model.tick(1'b1, 1'b0, o);
    u_jfp_prog_model.tick(1'b1, 1'b0, o);
    u_jfp_prog_model.tick(1'b0, 1'b0, o);
    repeat (8) @(posedge clock);
    `CHK(exec_cnt, 2)
    `CHK(prog_enabled, 1'b0)
  endtask : no_exec
  task summarize;
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    u_jfp_prog_model.tick(1'b0, 1'b0, o);
    cmd(15'h1234, 15'h2b5c, 0);
    unlock(JFP_UNLOCK_SIG ^ 16'h0001, 1'b0);
    unlock(JFP_UNLOCK_SIG, 1'b1);
    cmd(15'h4d31, 15'h0001, 1);
    cmd(15'h0ff0, 15'h7001, 2);
    page_load();
    page_read();
    bypass();
    no_exec();
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge clock);
    num_errors++;
    summarize();
  end
endmodule : tb
`default_nettype wire
